// file: hdl/pgtsa_pkg.sv
// Constants, register map and state types of the PCM/GCI time slot assigner.
// Assumes a single system clock far faster than the highway bit clock.
package pgtsa_pkg;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] ADDR_TX_SLOT = 8'h00;
    localparam logic [7:0] ADDR_TX_OFF = 8'h04;
    localparam logic [7:0] ADDR_RX_SLOT = 8'h08;
    localparam logic [7:0] ADDR_RX_OFF = 8'h0C;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;
    localparam logic [7:0] ADDR_TX_READ = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // Configuration register fields
    localparam int CFG_LINEAR = 0;
    localparam int CFG_SIGNAL = 1;
    localparam int CFG_HALF = 2;
    localparam int CFG_TX_RISE = 3;
    localparam int CFG_TX_ONE = 4;
    localparam int CFG_TX_TWO = 5;
    localparam int CFG_RX_TWO = 6;
    localparam int CFG_GCI_DBL = 7;
    // Reset values: channel 1 on slot 0, no offsets, falling edge, port one, companded
    localparam logic [6:0] TX_SLOT_RESET = 7'h00;
    localparam logic [6:0] RX_SLOT_RESET = 7'h00;
    localparam logic [2:0] TX_OFF_RESET = 3'h0;
    localparam logic [2:0] RX_OFF_RESET = 3'h0;
    localparam logic [7:0] CFG_RESET = 8'h10;
    // Synchronised pin indices
    localparam int PIN_CLK = 0;
    localparam int PIN_FRAME = 1;
    localparam int PIN_RX1 = 2;
    localparam int PIN_RX2 = 3;
    localparam int PIN_SEL0 = 4;
    localparam int PIN_SEL1 = 5;
    localparam int PIN_GCI = 6;
    localparam int PIN_COUNT = 7;
    // Window lengths in bits, minus one
    localparam logic [4:0] LEN_BYTE = 5'h07;
    localparam logic [4:0] LEN_WORD = 5'h0F;
    localparam logic [4:0] LEN_GCI = 5'h1F;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] CNT_MAX = 11'h7FF;

    typedef enum logic [0:0] {
        WIN_IDLE = 1'b0,
        WIN_SHIFT = 1'b1
    } pgtsa_win_t;

    typedef struct packed {
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] s3;
        logic [PIN_COUNT-1:0] lvl;
        logic div;
        logic fs_prev;
        logic frame_pend;
        logic [CNT_W-1:0] cnt;
        pgtsa_win_t tx_st;
        logic [4:0] tx_left;
        logic [31:0] tx_sh;
        logic tx_bit;
        logic [15:0] tx_read;
        pgtsa_win_t rx_st;
        logic [4:0] rx_left;
        logic rx_lin;
        logic rx_gci;
        logic [31:0] rx_sh;
        logic [7:0] rx_comp;
        logic rx_comp_vld;
        logic [15:0] rx_lin_word;
        logic rx_lin_vld;
        logic [15:0] rx_voice;
        logic [7:0] rx_mon;
        logic [7:0] rx_ci;
        logic rx_gci_vld;
        logic [6:0] tx_slot;
        logic [2:0] tx_off;
        logic [6:0] rx_slot;
        logic [2:0] rx_off;
        logic [7:0] cfg;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } pgtsa_state_t;
endpackage : pgtsa_pkg

// file: hdl/pgtsa_top.sv
// PCM highway / GCI time slot assigner for one codec channel, with AHB-Lite registers.
// Assumes highway pins are asynchronous to clk_sys_in and at least 4x slower.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns

// Function
// - Linear samples go out as 16 bits over two back-to-back slots; companded use one.
// - Linear coding exists only in PCM/MPI mode.
// - Signalling enabled: slot after companded byte carries signalling, forming one 16-bit block.
// - Frame pulse marks transmit slot 0; transmit positions count from it.
// - Slot selectors are 7 bits, up to 128 byte channels per frame.
// - Transmit bytes are shifted out most significant bit first.
// - 3-bit clock slot settings delay transmit and receive slots by 0 to 7 bits.
// - A transmit window crossing the frame end keeps driving arbitrary bits with strobe on.
// - A receive window cut by the next frame pulse is lost.
// - Data goes to port one, two or both; matching low strobes while sending.
// - Transmit data and strobes change on the selected bit clock edge.
// - Host can read the outgoing transmit sample through the register port.
// - Companded receive bytes go to the expander; linear words bypass it.
// - Receive data comes from port one or port two as programmed.
// - Frame pulse marks receive slot 0; receive positions count from it.
// - GCI upstream sends two voice bytes, monitor byte and command/indicate byte.
// - GCI channel is chosen by the two channel select pins.
// - GCI frame pulse marks GCI channel 0; channels reference it.
// - GCI mode has no signalling slot and no linear coding.
// - GCI data runs at the fixed data rate, halving a double-rate clock.
// - GCI downstream voice bytes go to the expander, monitor and C/I to control.
// - Linear samples are 16-bit two's complement, sign bit first.
// - Signalling byte: bit 7 first detector, bit 6 second, bit 2 clock fail.
// - Reset gives slot 0, zero clock slots and falling edge transmit.
// - Half-rate bit clocking advances data on every second rising bit clock edge.
module pgtsa_top (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic bit_clock_in,
    input wire logic frame_pulse_in,
    input wire logic rx_port_one_in,
    input wire logic rx_port_two_in,
    input wire logic gci_mode_in,
    input wire logic channel_select_low_in,
    input wire logic channel_select_high_in,
    output logic tx_port_one_out,
    output logic tx_port_one_oe_out,
    output logic tx_port_two_out,
    output logic tx_port_two_oe_out,
    output logic tx_enable_strobe_one_n_out,
    output logic tx_enable_strobe_two_n_out,
    input wire logic [7:0] tx_voice_a_in,
    input wire logic [7:0] tx_voice_b_in,
    input wire logic [15:0] tx_linear_in,
    input wire logic [7:0] tx_monitor_in,
    input wire logic [7:0] tx_command_in,
    input wire logic first_detector_bit_in,
    input wire logic second_detector_bit_in,
    input wire logic clock_fail_flag_in,
    output logic [7:0] rx_compand_out,
    output logic rx_compand_valid_out,
    output logic [15:0] rx_linear_out,
    output logic rx_linear_valid_out,
    output logic [15:0] rx_gci_voice_out,
    output logic [7:0] rx_gci_monitor_out,
    output logic [7:0] rx_gci_command_out,
    output logic rx_gci_valid_out
);
    import pgtsa_pkg::*;

    pgtsa_state_t q;
    pgtsa_state_t n;
    logic [PIN_COUNT-1:0] pins;
    logic gci;
    logic lin_eff;
    logic sig_eff;
    logic half;
    logic pclk_rise;
    logic pclk_fall;
    logic eff_rise;
    logic eff_fall;
    logic tx_edge;
    logic rx_edge;
    logic restart;
    logic [1:0] chan;
    logic [CNT_W-1:0] tx_base;
    logic [CNT_W-1:0] rx_base;
    logic [31:0] tx_word;
    logic [4:0] tx_len;
    logic [4:0] rx_len;
    logic [7:0] sig_byte;
    logic rx_din;
    logic tx_load;
    logic ap_valid;
    logic [31:0] rd_mux;

    assign pins = {gci_mode_in, channel_select_high_in, channel_select_low_in,
                   rx_port_two_in, rx_port_one_in, frame_pulse_in, bit_clock_in};

    always_comb begin
        n = q;
        // Pin synchroniser: a change counts only once stages two and three agree
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
        pclk_rise = n.lvl[PIN_CLK] & ~q.lvl[PIN_CLK];
        pclk_fall = ~n.lvl[PIN_CLK] & q.lvl[PIN_CLK];

        gci = q.lvl[PIN_GCI];
        chan = {q.lvl[PIN_SEL1], q.lvl[PIN_SEL0]};
        lin_eff = q.cfg[CFG_LINEAR] & ~gci;
        sig_eff = q.cfg[CFG_SIGNAL] & ~gci & ~q.cfg[CFG_LINEAR];

        // Half rate: one data bit spans two bit clock periods, shifted on rises only
        half = gci ? q.cfg[CFG_GCI_DBL] : q.cfg[CFG_HALF];
        if (half && pclk_rise) begin
            n.div = ~q.div;
        end
        eff_rise = half ? (pclk_rise & ~q.div) : pclk_rise;
        eff_fall = half ? (pclk_rise & q.div) : pclk_fall;
        tx_edge = q.cfg[CFG_TX_RISE] ? eff_rise : eff_fall;
        rx_edge = q.cfg[CFG_TX_RISE] ? eff_fall : eff_rise;

        // Frame pulse is sampled away from the transmit edge and acted on at the next one
        if (rx_edge) begin
            n.fs_prev = q.lvl[PIN_FRAME];
            if (q.lvl[PIN_FRAME] && !q.fs_prev) begin
                n.frame_pend = 1'b1;
            end
        end
        restart = tx_edge & q.frame_pend;
        if (restart) begin
            n.cnt = '0;
            n.frame_pend = 1'b0;
        end else if (tx_edge && q.cnt != CNT_MAX) begin
            n.cnt = q.cnt + 11'h001;
        end

        // Slot positions: groups of eight bits plus the clock slot delay in PCM; 32-bit channels from the select pins in GCI
        tx_base = gci ? {4'h0, chan, 5'h00} : ({1'b0, q.tx_slot, 3'h0} + {8'h00, q.tx_off});
        rx_base = gci ? {4'h0, chan, 5'h00} : ({1'b0, q.rx_slot, 3'h0} + {8'h00, q.rx_off});

        sig_byte = {first_detector_bit_in, second_detector_bit_in, 3'h0, clock_fail_flag_in, 2'h0};
        if (gci) begin
            tx_word = {tx_voice_a_in, tx_voice_b_in, tx_monitor_in, tx_command_in};
            tx_len = LEN_GCI;
        end else if (lin_eff) begin
            tx_word = {tx_linear_in, 16'h0000};
            tx_len = LEN_WORD;
        end else if (sig_eff) begin
            tx_word = {tx_voice_a_in, sig_byte, 16'h0000};
            tx_len = LEN_WORD;
        end else begin
            tx_word = {tx_voice_a_in, 24'h000000};
            tx_len = LEN_BYTE;
        end

        // Transmit window; not cut by a frame restart, so a late slot runs into the fraction
        tx_load = 1'b0;
        if (tx_edge) begin
            case (q.tx_st)
                WIN_IDLE: begin
                    if (n.cnt == tx_base) begin
                        tx_load = 1'b1;
                        n.tx_st = WIN_SHIFT;
                        n.tx_sh = tx_word;
                        n.tx_bit = tx_word[31];
                        n.tx_left = tx_len;
                        n.tx_read = tx_word[31:16];
                    end
                end
                WIN_SHIFT: begin
                    if (q.tx_left == 5'h00) begin
                        n.tx_st = WIN_IDLE;
                    end else begin
                        n.tx_sh = {q.tx_sh[30:0], 1'b0};
                        n.tx_bit = q.tx_sh[30];
                        n.tx_left = q.tx_left - 5'h01;
                    end
                end
                default: n.tx_st = WIN_IDLE;
            endcase
        end

        // Receive window
        rx_din = (q.cfg[CFG_RX_TWO] && !gci) ? q.lvl[PIN_RX2] : q.lvl[PIN_RX1];
        rx_len = gci ? LEN_GCI : (lin_eff ? LEN_WORD : LEN_BYTE);
        n.rx_comp_vld = 1'b0;
        n.rx_lin_vld = 1'b0;
        n.rx_gci_vld = 1'b0;
        if (restart) begin
            n.rx_st = WIN_IDLE;
        end else if (rx_edge) begin
            case (q.rx_st)
                WIN_IDLE: begin
                    if (q.cnt == rx_base) begin
                        n.rx_st = WIN_SHIFT;
                        n.rx_sh = {q.rx_sh[30:0], rx_din};
                        n.rx_left = rx_len - 5'h01;
                        n.rx_lin = lin_eff;
                        n.rx_gci = gci;
                    end
                end
                WIN_SHIFT: begin
                    n.rx_sh = {q.rx_sh[30:0], rx_din};
                    n.rx_left = q.rx_left - 5'h01;
                    if (q.rx_left == 5'h00) begin
                        n.rx_st = WIN_IDLE;
                        if (q.rx_gci) begin
                            n.rx_voice = n.rx_sh[31:16];
                            n.rx_mon = n.rx_sh[15:8];
                            n.rx_ci = n.rx_sh[7:0];
                            n.rx_gci_vld = 1'b1;
                        end else if (q.rx_lin) begin
                            n.rx_lin_word = n.rx_sh[15:0];
                            n.rx_lin_vld = 1'b1;
                        end else begin
                            n.rx_comp = n.rx_sh[7:0];
                            n.rx_comp_vld = 1'b1;
                        end
                    end
                end
                default: n.rx_st = WIN_IDLE;
            endcase
        end

        // AHB-Lite slave: zero wait states, writes land in the data phase
        ap_valid = hsel_in & htrans_in[1] & hready_in;
        if (q.ap_wr) begin
            case (q.ap_addr)
                ADDR_TX_SLOT: n.tx_slot = hwdata_in[6:0];
                ADDR_TX_OFF: n.tx_off = hwdata_in[2:0];
                ADDR_RX_SLOT: n.rx_slot = hwdata_in[6:0];
                ADDR_RX_OFF: n.rx_off = hwdata_in[2:0];
                ADDR_CONFIG: n.cfg = hwdata_in[7:0];
                default: n.cfg = n.cfg;
            endcase
        end
        n.ap_wr = ap_valid & hwrite_in;
        n.ap_addr = {haddr_in[7:2], 2'b00};
        // Read mux sees the write of the previous transfer, so back-to-back access is coherent
        case ({haddr_in[7:2], 2'b00})
            ADDR_TX_SLOT: rd_mux = {25'h0000000, n.tx_slot};
            ADDR_TX_OFF: rd_mux = {29'h00000000, n.tx_off};
            ADDR_RX_SLOT: rd_mux = {25'h0000000, n.rx_slot};
            ADDR_RX_OFF: rd_mux = {29'h00000000, n.rx_off};
            ADDR_CONFIG: rd_mux = {24'h000000, n.cfg};
            ADDR_TX_READ: rd_mux = {16'h0000, q.tx_read};
            ADDR_STATUS: rd_mux = {15'h0000, gci, chan, q.tx_st, q.rx_st, 1'b0, q.cnt};
            default: rd_mux = 32'h00000000;
        endcase
        if (ap_valid && !hwrite_in) begin
            n.rdata = rd_mux;
        end

        if (!nrst_in) begin
            n = '0;
            n.tx_slot = TX_SLOT_RESET;
            n.rx_slot = RX_SLOT_RESET;
            n.tx_off = TX_OFF_RESET;
            n.rx_off = RX_OFF_RESET;
            n.cfg = CFG_RESET;
            n.tx_st = WIN_IDLE;
            n.rx_st = WIN_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        q <= n;
    end

    // Port two is silent in GCI mode: upstream uses a single line
    assign tx_port_one_out = q.tx_bit;
    assign tx_port_two_out = q.tx_bit;
    assign tx_port_one_oe_out = (q.tx_st == WIN_SHIFT) & (q.cfg[CFG_TX_ONE] | gci);
    assign tx_port_two_oe_out = (q.tx_st == WIN_SHIFT) & q.cfg[CFG_TX_TWO] & ~gci;
    assign tx_enable_strobe_one_n_out = ~tx_port_one_oe_out;
    assign tx_enable_strobe_two_n_out = ~tx_port_two_oe_out;
    assign hrdata_out = q.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign rx_compand_out = q.rx_comp;
    assign rx_compand_valid_out = q.rx_comp_vld;
    assign rx_linear_out = q.rx_lin_word;
    assign rx_linear_valid_out = q.rx_lin_vld;
    assign rx_gci_voice_out = q.rx_voice;
    assign rx_gci_monitor_out = q.rx_mon;
    assign rx_gci_command_out = q.rx_ci;
    assign rx_gci_valid_out = q.rx_gci_vld;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    a_idle_strobes_high: assert property ((q.tx_st == WIN_IDLE) |-> (tx_enable_strobe_one_n_out &&
        tx_enable_strobe_two_n_out && !tx_port_one_oe_out && !tx_port_two_oe_out))
        else $error("strobe or drive active outside a window");
    a_linear_two_slots: assert property ((tx_load && lin_eff) |=> (q.tx_left == 5'h0F))
        else $error("linear sample not given sixteen bits");
    a_compand_one_slot: assert property ((tx_load && !gci && !lin_eff && !sig_eff) |=> (q.tx_left == 5'h07))
        else $error("companded byte not given eight bits");
    a_signal_block: assert property ((tx_load && sig_eff) |=> (q.tx_left == 5'h0F &&
        q.tx_sh[23:16] == $past(sig_byte)))
        else $error("signalling slot missing after companded byte");
    a_gci_no_linear: assert property (gci |-> (!lin_eff && !sig_eff))
        else $error("linear or signalling active in GCI mode");
    a_gci_four_bytes: assert property ((tx_load && gci) |=> (q.tx_left == 5'h1F))
        else $error("GCI upstream not four bytes");
    a_frame_restart: assert property (restart |=> (q.cnt == 11'h000 && q.rx_st == WIN_IDLE))
        else $error("frame pulse did not restart the count");
    a_tx_edge_only: assert property ($changed(q.tx_bit) |-> $past(tx_edge))
        else $error("transmit data changed off the selected edge");
    a_msb_first: assert property ((tx_load ##1 (q.tx_st == WIN_SHIFT && q.tx_left != 5'h00)[*1] ##0 tx_edge)
        |=> (q.tx_bit == $past(q.tx_sh[30])))
        else $error("transmit bit order wrong");
    a_rx_port_select: assert property ((rx_edge && q.rx_st == WIN_SHIFT && q.cfg[CFG_RX_TWO] && !gci)
        |=> (q.rx_sh[0] == $past(q.lvl[PIN_RX2])))
        else $error("receive bit not taken from port two");

    c_linear_sent: cover property (tx_load && lin_eff);
    c_signal_sent: cover property (tx_load && sig_eff);
    c_gci_received: cover property (q.rx_gci_vld);
    c_compand_received: cover property (q.rx_comp_vld);
endmodule : pgtsa_top

// file: testbench/pgtsa_highway.sv
// Behavioural highway controller facing the time slot assigner.
// Assumes the slot assigner transmits on the falling bit clock edge and samples on the rising edge.
`timescale 1ns/1ns
module pgtsa_highway #(
    parameter int FRAME_BITS = 32,
    parameter int HALF_NS = 80
) (
    output logic bit_clock_out,
    output logic frame_pulse_out,
    output logic rx_one_out,
    output logic rx_two_out,
    input wire logic tx_one_in,
    input wire logic tx_two_in,
    input wire logic oe_one_in,
    input wire logic oe_two_in,
    input wire logic [31:0] rx_word_in,
    output logic [31:0] cap_data_out,
    output logic [31:0] cap_m1_out,
    output logic [31:0] cap_m2_out,
    output int frame_cnt_out
);
    int idx;
    logic [31:0] d;
    logic [31:0] m1;
    logic [31:0] m2;
    initial begin
        bit_clock_out = 1'b1;
        frame_pulse_out = 1'b0;
        rx_one_out = 1'b1;
        rx_two_out = 1'b0;
        idx = FRAME_BITS - 1;
        frame_cnt_out = 0;
        forever #HALF_NS bit_clock_out = ~bit_clock_out;
    end
    // Port two carries the inverse pattern so a wrong port choice shows
    always @(negedge bit_clock_out) begin
        idx = (idx == FRAME_BITS - 1) ? 0 : idx + 1;
        rx_one_out = rx_word_in[31 - idx];
        rx_two_out = ~rx_word_in[31 - idx];
        frame_pulse_out = (idx == FRAME_BITS - 1);
    end
    always @(posedge bit_clock_out) begin
        d[31 - idx] = oe_one_in ? tx_one_in : tx_two_in;
        m1[31 - idx] = oe_one_in;
        m2[31 - idx] = oe_two_in;
        if (idx == FRAME_BITS - 1) begin
            cap_data_out = d;
            cap_m1_out = m1;
            cap_m2_out = m2;
            frame_cnt_out++;
        end
    end
endmodule : pgtsa_highway

// file: testbench/pgtsa_top_tb.sv
// Self-checking bench for the PCM time slot assigner, registers over AHB-Lite.
// Assumes a 32-bit frame from the highway model; GCI pins are held in PCM mode.
`timescale 1ns/1ns
module pgtsa_top_tb;
    import pgtsa_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, bclk, fpulse, rx1, rx2;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, cap_d, cap_m1, cap_m2, rd;
    logic [1:0] htrans = 2'b00;
    logic hreadyout, hresp, tx1, oe1, tx2, oe2, stb1_n, stb2_n, cv, lv, gv;
    logic [7:0] voice_a = 8'h00, rx_comp, comp_last = 8'h00, gmon, gcmd;
    logic [15:0] linear = 16'h0000, rx_lin, lin_last = 16'h0000, gvoice;
    logic det1 = 1'b0, det2 = 1'b0, clock_fail_flag = 1'b0;
    logic [7:0] mon = 8'h00, cmd = 8'h00;
    logic [31:0] rx_word = 32'hC33C5AA5;
    int frame_cnt, error_cnt = 0, tests_run = 0, cyc = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    pgtsa_top u_pgtsa_top (.clk_sys_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .bit_clock_in(bclk),
        .frame_pulse_in(fpulse), .rx_port_one_in(rx1), .rx_port_two_in(rx2), .gci_mode_in(1'b0),
        .channel_select_low_in(1'b0), .channel_select_high_in(1'b0), .tx_port_one_out(tx1),
        .tx_port_one_oe_out(oe1), .tx_port_two_out(tx2), .tx_port_two_oe_out(oe2),
        .tx_enable_strobe_one_n_out(stb1_n), .tx_enable_strobe_two_n_out(stb2_n), .tx_voice_a_in(voice_a),
        .tx_voice_b_in(8'h00), .tx_linear_in(linear), .tx_monitor_in(mon), .tx_command_in(cmd),
        .first_detector_bit_in(det1), .second_detector_bit_in(det2), .clock_fail_flag_in(clock_fail_flag),
        .rx_compand_out(rx_comp), .rx_compand_valid_out(cv), .rx_linear_out(rx_lin),
        .rx_linear_valid_out(lv), .rx_gci_voice_out(gvoice), .rx_gci_monitor_out(gmon),
        .rx_gci_command_out(gcmd), .rx_gci_valid_out(gv));

    // The strobes are sampled as the enables' inverse; the model sees the enables
    pgtsa_highway u_pgtsa_highway (.bit_clock_out(bclk), .frame_pulse_out(fpulse), .rx_one_out(rx1),
        .rx_two_out(rx2), .tx_one_in(tx1), .tx_two_in(tx2), .oe_one_in(~stb1_n), .oe_two_in(~stb2_n),
        .rx_word_in(rx_word), .cap_data_out(cap_d), .cap_m1_out(cap_m1), .cap_m2_out(cap_m2),
        .frame_cnt_out(frame_cnt));

    always @(posedge clk) begin
        if (cv === 1'b1) comp_last <= rx_comp;
        if (lv === 1'b1) lin_last <= rx_lin;
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("BAD t=%0t run did not finish", $time);
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Address phase held until hready, then data phase until hready again
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask : ahb

    task automatic t_reset();
        chk(hresp, 32'h0, "response");
        ahb(1'b0, ADDR_TX_SLOT, 32'h0, rd);
        chk(rd, {25'h0, TX_SLOT_RESET}, "tx slot reset");
        ahb(1'b0, ADDR_TX_OFF, 32'h0, rd);
        chk(rd, 32'h0, "tx offset reset");
        ahb(1'b0, ADDR_RX_SLOT, 32'h0, rd);
        chk(rd, 32'h0, "rx slot reset");
        ahb(1'b0, ADDR_RX_OFF, 32'h0, rd);
        chk(rd, 32'h0, "rx offset reset");
        ahb(1'b0, ADDR_CONFIG, 32'h0, rd);
        chk(rd, 32'h10, "config reset falling edge");
        ahb(1'b1, 8'h1C, 32'hFFFFFFFF, rd);
        ahb(1'b0, 8'h1C, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        $display("test reset done");
    endtask : t_reset

    // Programs the slots, lets three frames pass, then judges the last whole frame
    task automatic run_pcm(input string name, input logic [7:0] cfg, input logic [6:0] ts, input logic [2:0] to,
            input logic [6:0] rs, input logic [2:0] ro, input logic [15:0] txw);
        int n0, st, rst;
        logic [31:0] m, rw;
        ahb(1'b1, ADDR_TX_SLOT, {25'h0, ts}, rd);
        ahb(1'b1, ADDR_TX_OFF, {29'h0, to}, rd);
        ahb(1'b1, ADDR_RX_SLOT, {25'h0, rs}, rd);
        ahb(1'b1, ADDR_RX_OFF, {29'h0, ro}, rd);
        ahb(1'b1, ADDR_CONFIG, {24'h0, cfg}, rd);
        n0 = frame_cnt;
        while (frame_cnt < n0 + 3) @(posedge clk);
        st = ts * 8 + to;
        rst = rs * 8 + ro;
        m = ((cfg[CFG_LINEAR] | cfg[CFG_SIGNAL]) ? 32'hFFFF0000 : 32'hFF000000) >> st;
        chk(cap_d & m, ({txw, 16'h0000} >> st) & m, {name, " tx data"});
        chk(cap_m1, cfg[CFG_TX_ONE] ? m : 32'h0, {name, " strobe one"});
        chk(cap_m2, cfg[CFG_TX_TWO] ? m : 32'h0, {name, " strobe two"});
        rw = cfg[CFG_RX_TWO] ? ~rx_word : rx_word;
        if (cfg[CFG_LINEAR]) chk({16'h0, lin_last}, (rw >> (16 - rst)) & 32'hFFFF, {name, " rx"});
        else chk({24'h0, comp_last}, (rw >> (24 - rst)) & 32'hFF, {name, " rx"});
        $display("test %s done", name);
    endtask : run_pcm

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        @(posedge clk) voice_a <= 8'hA5;
        run_pcm("companded", 8'h10, 7'd2, 3'd0, 7'd1, 3'd0, 16'hA500);
        run_pcm("offset", 8'h10, 7'd0, 3'd3, 7'd1, 3'd5, 16'hA500);
        @(posedge clk) linear <= 16'h8123;
        run_pcm("linear", 8'h11, 7'd1, 3'd0, 7'd2, 3'd0, 16'h8123);
        ahb(1'b0, ADDR_TX_READ, 32'h0, rd);
        chk(rd, 32'h8123, "host read of tx word");
        @(posedge clk) det1 <= 1'b1;
        clock_fail_flag <= 1'b1;
        run_pcm("signalling", 8'h12, 7'd0, 3'd0, 7'd0, 3'd0, 16'hA584);
        @(posedge clk) det1 <= 1'b0;
        det2 <= 1'b1;
        run_pcm("second detector", 8'h12, 7'd1, 3'd0, 7'd0, 3'd0, 16'hA544);
        run_pcm("ports", 8'h70, 7'd1, 3'd2, 7'd1, 3'd0, 16'hA500);
        print_verdict();
    end
endmodule : pgtsa_top_tb
